// ### rtl/skf_cfg.svh
/*
 * constants of the key factory reset engine.
 * assumes inclusion by bare name.
 */
`ifndef SKF_CFG_SVH
`define SKF_CFG_SVH

// apb byte offsets
`define SKF_OFF_CTRL        12'h000
`define SKF_OFF_STATUS      12'h004
`define SKF_OFF_ERR         12'h008
`define SKF_OFF_CMD         12'h00C
`define SKF_OFF_PARAM1      12'h010

// prescale field
`define SKF_CTRL_DIV_LSB    0
`define SKF_CTRL_DIV_MSB    7
`define SKF_CTRL_DIV_RST    8'h1D

// status bits
`define SKF_ST_BUSY         0
`define SKF_ST_BOOT_OK      1
`define SKF_ST_SYSMEM_ERR   2
`define SKF_ST_RESET_LOCK   3
`define SKF_ST_RAND_READY   5

// command codes (arbitrary)
`define SKF_CMD_RANDOM_INIT 32'h0000_000A
`define SKF_CMD_DEBUG_CHAL  32'h0000_0012
`define SKF_CMD_DEBUG_AUTH  32'h0000_0013

// error codes
`define SKF_ERR_SUCCESS     32'h0000_0001
`define SKF_ERR_SEQUENCE    32'h0000_0002
`define SKF_ERR_KEY_WP      32'h0000_0004
`define SKF_ERR_RNG         32'h0000_0008
`define SKF_ERR_AUTH        32'h0000_0010
`define SKF_ERR_UNKNOWN     32'h0000_0020
`define SKF_ERR_RST         32'h0000_0000

// slot attribute bits
`define SKF_ATTR_WP         4
`define SKF_ATTR_BP         3
`define SKF_ATTR_DP         2
`define SKF_ATTR_KU         1
`define SKF_ATTR_WC         0

// debug constant, message lengths in bits
`define SKF_DEBUG_CONST     128'h0103_5348_4500_8000_0000_0000_0000_00B0
`define SKF_AUTH_MSG_BITS   9'h0F8
`define SKF_BOOT_MSG_BITS   9'h010

// ticks to random ready
`define SKF_RNG_INIT_TICKS  8'h10
`define SKF_RNG_SEED        128'h6A09_E667_BB67_AE85_3C6E_F372_A54F_F53A

`define SKF_WORDS_PER_BLOCK 3'h4
`define SKF_WORD_STEP       32'h0000_0004

`endif

// ### rtl/skf_pkg.sv
/*
 * types of the key factory reset engine.
 * assumes skf_cfg.svh for constants.
 */
package skf_pkg;

    typedef enum logic [5:0] {
        SKF_IDLE     = 6'b00_0001,
        SKF_RNG_WAIT = 6'b00_0010,
        SKF_CHAL_WR  = 6'b00_0100,
        SKF_AUTH_RD  = 6'b00_1000,
        SKF_AUTH_MAC = 6'b01_0000,
        SKF_BOOT_IMAGE_TAG = 6'b10_0000
    } skf_state_type;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } skf_mem_req_type;

    typedef struct packed {
        logic         valid;
        logic         boot_key;
        logic [127:0] derive_const;
        logic [8:0]   len_bits;
        logic [247:0] msg;
    } skf_mac_req_type;

    typedef struct packed {
        logic         done;
        logic [127:0] tag;
    } skf_mac_rsp_type;

endpackage

// ### rtl/skf_random_source.sv
/*
 * true random source: prescaled entropy sampling into a 128-bit pool.
 * assumes software keeps the sampling rate in range.
 */
`timescale 1ns/1ps
`include "skf_cfg.svh"

module skf_random_source #(
    parameter int unsigned DIV_W = 8
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [DIV_W-1:0]   prescale,
    input  wire logic               init_start,
    input  wire logic               entropy_bit,
    output logic                    ready,
    output logic [127:0]            rand_value
);

    logic [DIV_W-1:0] div_cnt_q;
    logic             tick;
    logic [7:0]       init_cnt_q;
    logic             ready_q;
    logic             armed_q;
    logic [127:0]     pool_q;

    assign tick = (div_cnt_q == prescale);

    // divided clock as an enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= '0;
        end else if (tick || init_start) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_q <= 8'h00;
            ready_q    <= 1'b0;
            armed_q    <= 1'b0;
        end else if (init_start) begin
            init_cnt_q <= 8'h00;
            ready_q    <= 1'b0;
            armed_q    <= 1'b1;
        end else if (tick && armed_q && !ready_q) begin
            init_cnt_q <= init_cnt_q + 8'h01;
            ready_q    <= (init_cnt_q == (`SKF_RNG_INIT_TICKS - 8'h01));
        end
    end

    // lfsr keeps mixing, so challenges differ without entropy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pool_q <= `SKF_RNG_SEED;
        end else if (tick) begin
            pool_q <= {pool_q[126:0],
                       pool_q[127] ^ pool_q[125] ^ pool_q[100] ^ pool_q[98] ^ entropy_bit};
        end
    end

    assign ready      = ready_q;
    assign rand_value = pool_q;

endmodule

// ### rtl/skf_engine.sv
/*
 * key factory reset engine: apb registers, command
 * sequencer, slot attributes, boot tag generation.
 * assumes an external kdf and cmac engine and a
 * word memory port that acks each request with
 * a one-cycle pulse, after any wait cycles.
 */
// The implementer's own choices: the APB slave port and the register addresses.
// Functional notes
// (RL1) factory reset needs no write protected slot.
// (RL2) challenge then authorization erases all user slots.
// (RL3) software inits the random source before a challenge.
// (RL4) software keeps the random clock in 500 kHz to 2 MHz.
// (RL5) status bit 0x20 flags the random source ready.
// (RL6) a challenge writes 128 random bits at pointer one.
// (RL7) the unlock key is the kdf of master key and debug constant.
// (RL8) authorization is a cmac over challenge and 120-bit id.
// (RL9) software sets pointer one then writes the command.
// (RL10) a match reports the success code, else a failure code.
// (RL11) software waits for busy clear between commands.
// (RL12) a fresh part stores the boot tag, then sets boot ok.
// (RL13) no valid reset halfword flags a system memory error.
// (RL14) each slot holds five attribute bits.
// (RL15) a write protected slot is never changed or erased.
// (RL16) busy holds from command write until results are valid.
`timescale 1ns/1ps
`include "skf_cfg.svh"

module skf_engine #(
    parameter int unsigned SLOTS = 12,
    parameter int unsigned DIV_W = 8
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    output skf_pkg::skf_mem_req_type      mem_req,
    input  wire logic                     mem_ack,
    input  wire logic [31:0]              mem_rdata,
    output skf_pkg::skf_mac_req_type      mac_req,
    input  wire skf_pkg::skf_mac_rsp_type mac_rsp,
    input  wire logic [119:0]             unique_part_id,
    input  wire logic                     entropy_bit,
    input  wire logic                     boot_start,
    input  wire logic                     reset_config_valid,
    input  wire logic [15:0]              reset_config_halfword,
    input  wire logic                     prov_we,
    input  wire logic [3:0]               prov_slot,
    input  wire logic [4:0]               prov_attr,
    output logic [127:0]                  boot_image_tag,
    output logic [SLOTS-1:0]              slot_valid
);

    skf_pkg::skf_state_type   state_q;
    skf_pkg::skf_mem_req_type mem_q;
    skf_pkg::skf_mac_req_type mac_q;

    logic [DIV_W-1:0] prescale_q;
    logic [31:0]      param_one_q;
    logic [31:0]      err_q;
    logic             busy_q;
    logic             boot_ok_q;
    logic             sysmem_err_q;
    logic             chal_valid_q;
    logic [127:0]     chal_q;
    logic [127:0]     auth_q;
    logic [127:0]     boot_tag_q;
    logic [2:0]       word_q;
    logic [4:0]       attr_q [SLOTS];
    logic [SLOTS-1:0] valid_q;
    logic             rng_init;
    logic             rng_ready;
    logic [127:0]     rng_value;
    logic             any_wp;
    logic             bus_wr;
    logic             cmd_go;
    logic             last_word;
    logic [31:0]      word_addr;

    function automatic logic [31:0] block_word(input logic [127:0] blk, input logic [2:0] idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx[1:0])
            2'h0:    w = blk[127:96];
            2'h1:    w = blk[95:64];
            2'h2:    w = blk[63:32];
            default: w = blk[31:0];
        endcase
        return w;
    endfunction

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        return addr == off;
    endfunction

    // any locked slot blocks factory reset
    always_comb begin
        any_wp = 1'b0;
        for (int i = 0; i < SLOTS; i++) begin
            any_wp = any_wp | (valid_q[i] & attr_q[i][`SKF_ATTR_WP]); // [RL1] [RL15]
        end
    end

    // apb: zero wait states
    assign pready  = 1'b1;
    assign bus_wr  = psel && penable && pwrite;
    assign cmd_go  = bus_wr && hit(paddr, `SKF_OFF_CMD) && !busy_q;
    assign pslverr = psel && penable && !(hit(paddr, `SKF_OFF_CTRL) || hit(paddr, `SKF_OFF_STATUS)
                     || hit(paddr, `SKF_OFF_ERR) || hit(paddr, `SKF_OFF_CMD)
                     || hit(paddr, `SKF_OFF_PARAM1));

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                `SKF_OFF_CTRL:   prdata[`SKF_CTRL_DIV_MSB:`SKF_CTRL_DIV_LSB] = prescale_q;
                `SKF_OFF_STATUS: begin
                    prdata[`SKF_ST_BUSY]       = busy_q;      // [RL16]
                    prdata[`SKF_ST_BOOT_OK]    = boot_ok_q;   // [RL12]
                    prdata[`SKF_ST_SYSMEM_ERR] = sysmem_err_q; // [RL13]
                    prdata[`SKF_ST_RESET_LOCK] = any_wp;
                    prdata[`SKF_ST_RAND_READY] = rng_ready;   // [RL5]
                end
                `SKF_OFF_ERR:    prdata = err_q;
                `SKF_OFF_PARAM1: prdata = param_one_q;
                default:         prdata = 32'h0000_0000;
            endcase
        end
    end

    // prescale and pointer frozen while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_q  <= `SKF_CTRL_DIV_RST;
            param_one_q <= 32'h0000_0000;
        end else if (bus_wr && !busy_q) begin
            if (hit(paddr, `SKF_OFF_CTRL)) begin
                prescale_q <= pwdata[`SKF_CTRL_DIV_MSB:`SKF_CTRL_DIV_LSB];
            end
            if (hit(paddr, `SKF_OFF_PARAM1)) begin
                param_one_q <= pwdata;
            end
        end
    end

    assign rng_init  = cmd_go && (pwdata == `SKF_CMD_RANDOM_INIT);
    assign last_word = (word_q == (`SKF_WORDS_PER_BLOCK - 3'h1));
    assign word_addr = param_one_q + ({29'h0000_0000, word_q} * `SKF_WORD_STEP);

    skf_random_source #(
        .DIV_W (DIV_W)
    ) u_random (
        .pclk        (pclk),
        .presetn     (presetn),
        .prescale    (prescale_q),
        .init_start  (rng_init),
        .entropy_bit (entropy_bit),
        .ready       (rng_ready),
        .rand_value  (rng_value)
    );

    // command sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= skf_pkg::SKF_IDLE;
            busy_q       <= 1'b0;
            err_q        <= `SKF_ERR_RST;
            chal_valid_q <= 1'b0;
            chal_q       <= '0;
            auth_q       <= '0;
            word_q       <= 3'h0;
            mem_q        <= '0;
            mac_q        <= '0;
            boot_ok_q    <= 1'b0;
            sysmem_err_q <= 1'b0;
            boot_tag_q   <= '0;
        end else begin
            case (state_q)
                skf_pkg::SKF_IDLE: begin
                    if (cmd_go) begin
                        busy_q <= 1'b1; // [RL16]
                        word_q <= 3'h0;
                        case (pwdata)
                            `SKF_CMD_RANDOM_INIT: begin
                                state_q <= skf_pkg::SKF_RNG_WAIT;
                            end
                            `SKF_CMD_DEBUG_CHAL: begin
                                if (!rng_ready) begin
                                    err_q  <= `SKF_ERR_RNG; // [RL3]
                                    busy_q <= 1'b0;
                                end else begin
                                    chal_q       <= rng_value;
                                    chal_valid_q <= 1'b0;
                                    state_q      <= skf_pkg::SKF_CHAL_WR;
                                end
                            end
                            `SKF_CMD_DEBUG_AUTH: begin
                                if (any_wp) begin
                                    err_q  <= `SKF_ERR_KEY_WP; // [RL1]
                                    busy_q <= 1'b0;
                                end else if (!chal_valid_q) begin
                                    err_q  <= `SKF_ERR_SEQUENCE; // [RL2]
                                    busy_q <= 1'b0;
                                end else begin
                                    state_q <= skf_pkg::SKF_AUTH_RD; // [RL9]
                                end
                            end
                            default: begin
                                err_q  <= `SKF_ERR_UNKNOWN;
                                busy_q <= 1'b0;
                            end
                        endcase
                    end else if (boot_start && valid_q == '0) begin
                        if (!reset_config_valid) begin
                            sysmem_err_q <= 1'b1; // [RL13]
                        end else begin
                            busy_q             <= 1'b1;
                            mac_q.valid        <= 1'b1; // [RL12]
                            mac_q.boot_key     <= 1'b1;
                            mac_q.derive_const <= '0;
                            mac_q.len_bits     <= `SKF_BOOT_MSG_BITS;
                            mac_q.msg          <= {reset_config_halfword, 232'h0};
                            state_q            <= skf_pkg::SKF_BOOT_IMAGE_TAG;
                        end
                    end
                end
                skf_pkg::SKF_RNG_WAIT: begin
                    if (rng_ready) begin
                        err_q   <= `SKF_ERR_SUCCESS; // [RL5]
                        busy_q  <= 1'b0;
                        state_q <= skf_pkg::SKF_IDLE;
                    end
                end
                skf_pkg::SKF_CHAL_WR: begin
                    // one word per ack, top word first
                    mem_q.req   <= !(mem_ack && last_word);
                    mem_q.we    <= 1'b1;
                    mem_q.addr  <= word_addr; // [RL6]
                    mem_q.wdata <= block_word(chal_q, word_q);
                    if (mem_q.req && mem_ack) begin
                        word_q <= word_q + 3'h1;
                        mem_q.addr  <= word_addr + `SKF_WORD_STEP;
                        mem_q.wdata <= block_word(chal_q, word_q + 3'h1);
                        if (last_word) begin
                            chal_valid_q <= 1'b1;
                            err_q        <= `SKF_ERR_SUCCESS;
                            busy_q       <= 1'b0;
                            state_q      <= skf_pkg::SKF_IDLE;
                        end
                    end
                end
                skf_pkg::SKF_AUTH_RD: begin
                    mem_q.req   <= !(mem_ack && last_word);
                    mem_q.we    <= 1'b0;
                    mem_q.addr  <= word_addr;
                    mem_q.wdata <= 32'h0000_0000;
                    if (mem_q.req && mem_ack) begin
                        word_q     <= word_q + 3'h1;
                        mem_q.addr <= word_addr + `SKF_WORD_STEP;
                        auth_q     <= {auth_q[95:0], mem_rdata};
                        if (last_word) begin
                            mac_q.valid        <= 1'b1;
                            mac_q.boot_key     <= 1'b0;
                            mac_q.derive_const <= `SKF_DEBUG_CONST; // [RL7]
                            mac_q.len_bits     <= `SKF_AUTH_MSG_BITS; // [RL8]
                            mac_q.msg          <= {chal_q, unique_part_id}; // [RL8]
                            state_q            <= skf_pkg::SKF_AUTH_MAC;
                        end
                    end
                end
                skf_pkg::SKF_AUTH_MAC: begin
                    if (mac_rsp.done) begin
                        mac_q.valid  <= 1'b0;
                        chal_valid_q <= 1'b0;
                        err_q        <= (mac_rsp.tag == auth_q && !any_wp) ?
                                        `SKF_ERR_SUCCESS : `SKF_ERR_AUTH; // [RL10]
                        busy_q       <= 1'b0;
                        state_q      <= skf_pkg::SKF_IDLE;
                    end
                end
                skf_pkg::SKF_BOOT_IMAGE_TAG: begin
                    if (mac_rsp.done) begin
                        mac_q.valid <= 1'b0;
                        boot_tag_q  <= mac_rsp.tag; // [RL12]
                        boot_ok_q   <= 1'b1;
                        busy_q      <= 1'b0;
                        state_q     <= skf_pkg::SKF_IDLE;
                    end
                end
                default: begin
                    state_q <= skf_pkg::SKF_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // slot 0 boot tag, other slots provisioned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                attr_q[i] <= 5'h00;
            end
        end else if (state_q == skf_pkg::SKF_AUTH_MAC && mac_rsp.done
                     && mac_rsp.tag == auth_q && !any_wp) begin
            valid_q <= '0; // [RL2]
            for (int i = 0; i < SLOTS; i++) begin
                attr_q[i] <= 5'h00;
            end
        end else if (state_q == skf_pkg::SKF_BOOT_IMAGE_TAG && mac_rsp.done) begin
            valid_q[0] <= 1'b1;
        end else if (prov_we && 32'(prov_slot) < SLOTS) begin
            if (!(valid_q[prov_slot] && attr_q[prov_slot][`SKF_ATTR_WP])) begin
                valid_q[prov_slot] <= 1'b1; // [RL15]
                attr_q[prov_slot]  <= prov_attr; // [RL14]
            end
        end
    end

    assign mem_req        = mem_q;
    assign mac_req        = mac_q;
    assign boot_image_tag = boot_tag_q;
    assign slot_valid     = valid_q;

endmodule

// ### sim/skf_engine_checker.sv
/* assertions on skf_engine ports.
   assumes binding into skf_engine. */
`timescale 1ns/1ps
`include "skf_cfg.svh"
module skf_engine_checker #(
    parameter int unsigned SLOTS = 12
) (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire skf_pkg::skf_mem_req_type mem_req,
    input wire logic                     mem_ack,
    input wire skf_pkg::skf_mac_req_type mac_req,
    input wire skf_pkg::skf_mac_rsp_type mac_rsp,
    input wire logic [119:0]             unique_part_id,
    input wire logic [15:0]              reset_config_halfword,
    input wire logic                     prov_we,
    input wire logic [4:0]               prov_attr,
    input wire logic [127:0]             boot_image_tag,
    input wire logic [SLOTS-1:0]         slot_valid
);
    logic wp_seen_q;
    // set by any provisioning write with the lock bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wp_seen_q <= 1'b0;
        else if (prov_we && prov_attr[`SKF_ATTR_WP]) wp_seen_q <= 1'b1;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_mem_hold: assert property (mem_req.req && !mem_ack |=> $stable(mem_req))
        else $error("mem request moved");
    a_mem_step: assert property (mem_ack |=> !mem_req.req ||
        mem_req.addr == $past(mem_req.addr) + 32'h0000_0004) else $error("bad word step");
    a_auth_msg: assert property (mac_req.valid && !mac_req.boot_key |->
        mac_req.len_bits == `SKF_AUTH_MSG_BITS && mac_req.msg[119:0] == unique_part_id)
        else $error("bad authorization message");
    a_debug_key: assert property (mac_req.valid && !mac_req.boot_key |->
        mac_req.derive_const == `SKF_DEBUG_CONST) else $error("bad derivation constant");
    a_mac_hold: assert property (mac_req.valid && !mac_rsp.done |=> $stable(mac_req))
        else $error("mac request moved");
    a_boot_msg: assert property (mac_req.valid && mac_req.boot_key |->
        mac_req.len_bits == `SKF_BOOT_MSG_BITS && mac_req.msg[247:232] == reset_config_halfword)
        else $error("bad boot tag message");
    a_boot_store: assert property (mac_rsp.done && mac_req.valid && mac_req.boot_key |=>
        boot_image_tag == $past(mac_rsp.tag) && slot_valid[0]) else $error("boot tag not stored");
    a_wp_keeps: assert property (wp_seen_q |=>
        (slot_valid & $past(slot_valid)) == $past(slot_valid)) else $error("slot erased while locked");
    c_boot_tag: cover property (mac_rsp.done && mac_req.boot_key);
    c_auth_mac: cover property (mac_rsp.done && !mac_req.boot_key);
    c_locked: cover property (wp_seen_q && slot_valid != '0);
endmodule
bind skf_engine skf_engine_checker #(.SLOTS(SLOTS)) u_chk (.pclk, .presetn, .mem_req,
    .mem_ack, .mac_req, .mac_rsp, .unique_part_id, .reset_config_halfword, .prov_we,
    .prov_attr, .boot_image_tag, .slot_valid);

// ### sim/skf_host_model.sv
/* partner: word memory and mac stand-in.
   assumes one request at a time; slow adds wait cycles. */
`timescale 1ns/1ps
module skf_host_model (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     slow,
    input wire skf_pkg::skf_mem_req_type mem_req,
    output logic                         mem_ack,
    output logic [31:0]                  mem_rdata,
    input wire skf_pkg::skf_mac_req_type mac_req,
    output skf_pkg::skf_mac_rsp_type     mac_rsp
);
    logic [31:0] mem [64];
    logic [2:0]  wait_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mem_ack, mem_rdata, mac_rsp, wait_q} <= '0;
        end else begin
            // idle outputs keep changing so stale data never looks valid
            {mem_ack, mac_rsp.done, mem_rdata, mac_rsp.tag} <= {2'b00, ~mem_rdata, ~mac_rsp.tag};
            if ((mem_req.req && !mem_ack) || (mac_req.valid && !mac_rsp.done)) begin
                wait_q <= wait_q + 3'h1;
                if (wait_q >= {slow, 2'b00}) begin
                    {wait_q, mem_ack, mac_rsp.done} <= {3'h0, mem_req.req, mac_req.valid};
                    mem_rdata <= mem[mem_req.addr[7:2]];
                    if (mem_req.req && mem_req.we) mem[mem_req.addr[7:2]] <= mem_req.wdata;
                    // xor stand-in for the cmac
                    mac_rsp.tag <= mac_req.msg[247:120] ^ {8'h00, mac_req.msg[119:0]}
                        ^ (mac_req.boot_key ? 128'h0 : mac_req.derive_const);
                end
            end
        end
    end
endmodule

// ### sim/tb_top.sv
/* bench for skf_engine, one task per scenario.
   assumes skf_host_model as partner. */
`timescale 1ns/1ps
`include "skf_cfg.svh"
module tb_top;
    localparam logic [119:0] UNIQUE_PART_ID = 120'h0011_2233_4455_6677_8899_AABB_CCDD_EE;
    logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
    logic                     mem_ack, slow, boot_start, rc_valid, prov_we;
    logic [11:0]              paddr, slots;
    logic [31:0]              pwdata, prdata, mem_rdata, r;
    logic [15:0]              rc_hw;
    logic [3:0]               prov_slot;
    logic [4:0]               prov_attr;
    logic [127:0]             tag, chal;
    skf_pkg::skf_mem_req_type mem_req;
    skf_pkg::skf_mac_req_type mac_req;
    skf_pkg::skf_mac_rsp_type mac_rsp;
    int                       fails = 0, checks = 0;
    always #10 pclk = ~pclk;
    // entropy taken from the partner's toggling idle data
    skf_engine DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mem_req, .mem_ack, .mem_rdata, .mac_req, .mac_rsp,
        .unique_part_id(UNIQUE_PART_ID), .entropy_bit(mem_rdata[0]), .boot_start,
        .reset_config_valid(rc_valid), .reset_config_halfword(rc_hw), .prov_we, .prov_slot,
        .prov_attr, .boot_image_tag(tag), .slot_valid(slots));
    skf_host_model MEM (.pclk, .presetn, .slow, .mem_req, .mem_ack, .mem_rdata, .mac_req,
        .mac_rsp);
    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] want);
        checks++;
        if (got !== want) $display("unexpected at %0t: got %h want %h", $time, got, want);
        if (got !== want) fails++;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        {r, slverr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) fails++;
        if (pready !== 1'b1) finish_test;
    endtask
    task automatic poll(input int i, input logic v);
        int n = 0;
        do apb(1'b0, `SKF_OFF_STATUS, 32'h0000_0000); while (r[i] !== v && ++n < 300);
        chk(128'(r[i]), 128'(v));
        if (r[i] !== v) finish_test;
    endtask
    task automatic run(input logic [31:0] cmd, input logic [31:0] err);
        apb(1'b1, `SKF_OFF_CMD, cmd);
        poll(`SKF_ST_BUSY, 1'b0);
        apb(1'b0, `SKF_OFF_ERR, 32'h0000_0000);
        chk(128'(r), 128'(err));
    endtask
    task automatic pulse(input logic b, input logic [3:0] s, input logic [4:0] a);
        @(posedge pclk);
        {boot_start, prov_we, prov_slot, prov_attr} <= {b, !b, s, a};
        @(posedge pclk);
        {boot_start, prov_we} <= 2'b00;
    endtask
    task automatic t_boot;
        pulse(1'b1, 4'h0, 5'h00);
        poll(`SKF_ST_SYSMEM_ERR, 1'b1);
        chk(128'(slots), 128'h0);
        {rc_valid, rc_hw} <= {1'b1, 16'hA55A};
        pulse(1'b1, 4'h0, 5'h00);
        poll(`SKF_ST_BOOT_OK, 1'b1);
        chk({tag[127:4], slots[3:0]}, {16'hA55A, 108'h0, 4'h1});
    endtask
    task automatic t_rng;
        // 50 MHz / 25 = 2 MHz
        apb(1'b1, `SKF_OFF_CTRL, 32'h0000_0018);
        run(`SKF_CMD_DEBUG_CHAL, `SKF_ERR_RNG);
        run(`SKF_CMD_RANDOM_INIT, `SKF_ERR_SUCCESS);
        poll(`SKF_ST_RAND_READY, 1'b1);
        run(32'h0000_00FF, `SKF_ERR_UNKNOWN);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk(128'({slverr, r}), {95'h0, 1'b1, 32'h0000_0000});
    endtask
    task automatic t_auth(input logic good, input logic [31:0] err, input logic [11:0] left);
        logic [127:0] a;
        apb(1'b1, `SKF_OFF_PARAM1, 32'h0000_0040);
        run(`SKF_CMD_DEBUG_CHAL, `SKF_ERR_SUCCESS);
        chal = {MEM.mem[16], MEM.mem[17], MEM.mem[18], MEM.mem[19]};
        a = chal ^ {8'h00, UNIQUE_PART_ID} ^ `SKF_DEBUG_CONST ^ {127'h0, !good};
        for (int i = 0; i < 4; i++) MEM.mem[32 + i] = a[127 - 32 * i -: 32];
        apb(1'b1, `SKF_OFF_PARAM1, 32'h0000_0080);
        run(`SKF_CMD_DEBUG_AUTH, err);
        chk(128'(slots), 128'(left));
    endtask
    task automatic t_wp;
        pulse(1'b0, 4'h4, 5'h11);
        poll(`SKF_ST_RESET_LOCK, 1'b1);
        run(`SKF_CMD_DEBUG_CHAL, `SKF_ERR_SUCCESS);
        run(`SKF_CMD_DEBUG_AUTH, `SKF_ERR_KEY_WP);
        chk(128'(slots), 128'h10);
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, slow, boot_start, rc_valid, prov_we} = '0;
        {paddr, pwdata, rc_hw, prov_slot, prov_attr} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_boot;
        t_rng;
        pulse(1'b0, 4'h2, 5'h03);
        pulse(1'b0, 4'h5, 5'h03);
        t_auth(1'b0, `SKF_ERR_AUTH, 12'h025);
        slow <= 1'b1;
        t_auth(1'b1, `SKF_ERR_SUCCESS, 12'h000);
        run(`SKF_CMD_DEBUG_AUTH, `SKF_ERR_SEQUENCE);
        t_wp;
        finish_test;
    end
endmodule
